// [rtl/ocp_delay_cnt.sv]
// Purpose: Delay counter that flags expiry after a loaded count of cycles.
// Assumes: Restart clears the count; count holds at terminal.
// Notes:   Shared by detect and release timing.
`timescale 1ns/100ps
module ocp_delay_cnt #(
  parameter int unsigned W = 28
) (
  // Clock and control
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_limit,
  // Result
  output logic              o_done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Count while running, clear when the condition drops
  assign cnt_next = !i_run ? '0 : (cnt_reg >= i_limit) ? cnt_reg : cnt_reg + 1'b1;
  assign o_done   = i_run && (cnt_reg + 1'b1 >= i_limit);

  // Counter register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// [rtl/ocp_fsm.sv]
// Purpose: Over-charge detector state machine driving the charge FET enable.
// Assumes: Comparator inputs are synchronous to i_clk; config is static.
// Notes:   Software may override config via CTRL when its enable bit is set.
`timescale 1ns/100ps
module ocp_fsm
  import ocp_pkg::*;
#(
  parameter int unsigned DET_CNT = DET_CYCLES,
  parameter int unsigned REL_CNT = REL_CYCLES,
  parameter int unsigned SHR_DIV = SHORTEN_DIV
) (
  // Clock, reset, enable
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // Comparator results and static variant straps
  input  wire ocp_pkg::ocp_cmp_t   i_cmp,
  input  wire ocp_pkg::ocp_cfg_t   i_cfg,
  // Avalon-MM slave
  input  wire ocp_pkg::ocp_av_req_t i_av,
  output logic [31:0]              o_av_readdata,
  output logic                     o_av_waitrequest,
  // Outputs
  output logic                     o_charge_en,
  output logic                     o_irq
);
  import ocp_pkg::*;

  // ==========================================================================
  // Delay limits
  localparam logic [CNT_W-1:0] DET_L  = CNT_W'(DET_CNT);
  localparam logic [CNT_W-1:0] REL_L  = CNT_W'(REL_CNT);
  localparam logic [CNT_W-1:0] DET_SL = CNT_W'((DET_CNT / SHR_DIV) > 0 ? DET_CNT / SHR_DIV : 1);
  localparam logic [CNT_W-1:0] REL_SL = CNT_W'((REL_CNT / SHR_DIV) > 0 ? REL_CNT / SHR_DIV : 1);

  ocp_state_t       state_reg;
  ocp_state_t       state_next;
  logic             en_reg;
  logic             en_next;
  logic [31:0]      ctrl_reg;
  logic [EV_W-1:0]  mask_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;

  // ==========================================================================
  // Effective configuration
  // Software override allows bench bring-up without re-strapping the part
  wire sw_ovr    = ctrl_reg[0];
  wire auto_rel  = sw_ovr ? ctrl_reg[1] : i_cfg.auto_release;
  wire zero_v_ok = sw_ovr ? ctrl_reg[2] : i_cfg.zero_v_ok;

  // ==========================================================================
  // Delay selection and release condition
  wire [CNT_W-1:0] det_lim = i_cmp.shorten ? DET_SL : DET_L;
  wire [CNT_W-1:0] rel_lim = i_cmp.shorten ? REL_SL : REL_L;

  // Latch variant: only charger removal or load below threshold releases
  wire below_thr  = !i_cmp.above_thr;
  wire rel_latch  = below_thr && (!i_cmp.charger || i_cmp.load);
  // Auto variant adds release at the release level regardless of charger
  wire rel_auto   = i_cmp.at_release
                  || (below_thr && !i_cmp.charger)
                  || (below_thr && i_cmp.load);
  wire rel_cond   = auto_rel ? rel_auto : rel_latch;

  wire det_run = (state_reg == OCP_DET_WAIT) && i_cmp.above_thr;
  wire rel_run = (state_reg == OCP_REL_WAIT) && rel_cond;
  wire det_done;
  wire rel_done;

  // Detect delay counter
  ocp_delay_cnt #(.W(CNT_W)) u_det (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_run   (det_run),
    .i_limit (det_lim),
    .o_done  (det_done)
  );

  // Release delay counter
  ocp_delay_cnt #(.W(CNT_W)) u_rel (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_run   (rel_run),
    .i_limit (rel_lim),
    .o_done  (rel_done)
  );

  // ==========================================================================
  // State transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OCP_NORMAL: begin
        if (i_cmp.above_thr) begin
          state_next = OCP_DET_WAIT;
        end
      end
      OCP_DET_WAIT: begin
        if (!i_cmp.above_thr) begin
          state_next = OCP_NORMAL;
        end else if (det_done) begin
          state_next = OCP_OVER;
        end
      end
      OCP_OVER: begin
        if (rel_cond) begin
          state_next = OCP_REL_WAIT;
        end
      end
      OCP_REL_WAIT: begin
        if (!rel_cond) begin
          state_next = OCP_OVER;
        end else if (rel_done) begin
          state_next = OCP_NORMAL;
        end
      end
      default: begin
        state_next = OCP_NORMAL;
      end
    endcase
  end

  // Enable low in over-charge, or while zero-volt charge is inhibited
  wire in_over  = (state_next == OCP_OVER) || (state_next == OCP_REL_WAIT);
  wire inhibit  = !zero_v_ok && i_cmp.below_inhibit;
  assign en_next = !in_over && !inhibit;

  // ==========================================================================
  // Events for the interrupt block
  wire ev_det = (state_reg == OCP_DET_WAIT) && (state_next == OCP_OVER);
  wire ev_rel = (state_reg == OCP_REL_WAIT) && (state_next == OCP_NORMAL);
  wire [EV_W-1:0] events = {ev_rel, ev_det};

  // State and output registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= OCP_NORMAL;
      en_reg    <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next;
      en_reg    <= en_next;
    end
  end
  assign o_charge_en = en_reg;

  // ==========================================================================
  // Checks on the state machine
  // Ages of the running attempts, kept apart from the delay counters
  logic [CNT_W-1:0] det_age_reg;
  logic [CNT_W-1:0] rel_age_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      det_age_reg <= '0;
      rel_age_reg <= '0;
    end else if (i_ce) begin
      det_age_reg <= det_run ? det_age_reg + 1'b1 : '0;
      rel_age_reg <= rel_run ? rel_age_reg + 1'b1 : '0;
    end
  end

  property p_reset_state;
    @(posedge i_clk)
      i_rst |=> (state_reg == OCP_NORMAL) && o_charge_en;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset did not give normal state with enable on");

  property p_normal_enable;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_NORMAL && !inhibit) |=> o_charge_en;
  endproperty
  a_normal_enable: assert property (p_normal_enable)
    else $error("enable dropped before detect delay ended");

  property p_detect_enable_low;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_DET_WAIT && det_done && i_cmp.above_thr) |=> !o_charge_en;
  endproperty
  a_detect_enable_low: assert property (p_detect_enable_low)
    else $error("enable not dropped after detect delay");

  property p_abandon_detect;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_DET_WAIT && !i_cmp.above_thr) |=> state_reg == OCP_NORMAL;
  endproperty
  a_abandon_detect: assert property (p_abandon_detect)
    else $error("detect not abandoned");

  property p_detect_delay;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ev_det) |-> (det_age_reg + 1'b1 >= det_lim);
  endproperty
  a_detect_delay: assert property (p_detect_delay)
    else $error("over-charge entered before detect delay");

  property p_latch_hold;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !auto_rel && state_reg == OCP_OVER && i_cmp.charger && !i_cmp.load)
        |=> state_reg == OCP_OVER;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch released with charger attached");

  property p_latch_release;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !auto_rel && state_reg == OCP_OVER && below_thr && !i_cmp.charger)
        |=> state_reg == OCP_REL_WAIT;
  endproperty
  a_latch_release: assert property (p_latch_release)
    else $error("latch ignored charger removal");

  property p_load_release;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_OVER && below_thr && i_cmp.load) |=> state_reg == OCP_REL_WAIT;
  endproperty
  a_load_release: assert property (p_load_release)
    else $error("load did not start release");

  property p_auto_release_level;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && auto_rel && state_reg == OCP_OVER && i_cmp.at_release)
        |=> state_reg == OCP_REL_WAIT;
  endproperty
  a_auto_release_level: assert property (p_auto_release_level)
    else $error("release level ignored");

  property p_auto_charger_release;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && auto_rel && state_reg == OCP_OVER && below_thr && !i_cmp.charger)
        |=> state_reg == OCP_REL_WAIT;
  endproperty
  a_auto_charger_release: assert property (p_auto_charger_release)
    else $error("auto release ignored charger removal");

  property p_auto_load_release;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && auto_rel && state_reg == OCP_OVER && below_thr && i_cmp.charger && i_cmp.load)
        |=> state_reg == OCP_REL_WAIT;
  endproperty
  a_auto_load_release: assert property (p_auto_load_release)
    else $error("auto release ignored load");

  property p_release_enable;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_REL_WAIT && rel_done && !inhibit)
        |=> (state_reg == OCP_NORMAL) && o_charge_en;
  endproperty
  a_release_enable: assert property (p_release_enable)
    else $error("enable not restored after release delay");

  property p_release_abort;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == OCP_REL_WAIT && !rel_cond) |=> state_reg == OCP_OVER && !o_charge_en;
  endproperty
  a_release_abort: assert property (p_release_abort)
    else $error("release not abandoned");

  property p_release_delay;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ev_rel) |-> (rel_age_reg + 1'b1 >= rel_lim);
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("released before release delay");

  property p_inhibit;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !zero_v_ok && i_cmp.below_inhibit) |=> !o_charge_en;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("zero-volt inhibit not applied");

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then acknowledge
  wire req     = i_av.read || i_av.write;
  wire take    = req && ack_reg && i_ce;   // Nothing is taken while frozen
  wire wr_ctrl = take && i_av.write && (i_av.address == ADDR_CTRL);
  wire wr_mask = take && i_av.write && (i_av.address == ADDR_IRQ_MASK);
  wire wr_stat = take && i_av.write && (i_av.address == ADDR_IRQ_STAT);
  wire [EV_W-1:0] irq_clr = wr_stat ? i_av.writedata[EV_W-1:0] : '0;
  wire [EV_W-1:0] irq_stat;

  ocp_irq #(.N(EV_W)) u_irq (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_ce     (i_ce),
    .i_event  (events),
    .i_clr    (irq_clr),
    .i_mask   (mask_reg),
    .o_status (irq_stat),
    .o_irq    (o_irq)
  );

  // Checks on the event bits and the interrupt line
  property p_irq_level;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ev_det && mask_reg[EV_DETECT] && !wr_mask) |=> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked detect event did not raise interrupt");

  property p_release_event;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ev_rel) |=> irq_stat[EV_RELEASE];
  endproperty
  a_release_event: assert property (p_release_event)
    else $error("release event not recorded");

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (i_av.address)
      ADDR_CTRL:     rdata_next = ctrl_reg;
      ADDR_STATUS:   rdata_next = {28'h0000000, en_reg, inhibit, state_reg};
      ADDR_IRQ_STAT: rdata_next = {30'h00000000, irq_stat};
      ADDR_IRQ_MASK: rdata_next = {30'h00000000, mask_reg};
      default:       rdata_next = 32'h0000_0000;
    endcase
  end

  assign o_av_waitrequest = req && !(ack_reg && i_ce); // Stall while frozen
  assign o_av_readdata    = rdata_reg;

  // Bus registers; ack toggles so every request sees one wait cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg  <= CTRL_RST;
      mask_reg  <= MASK_RST[EV_W-1:0];
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_reg   <= req && !ack_reg;
      rdata_reg <= rdata_next;
      if (wr_ctrl) begin
        ctrl_reg <= {29'h00000000, i_av.writedata[2:0]};
      end
      if (wr_mask) begin
        mask_reg <= i_av.writedata[EV_W-1:0];
      end
    end
  end

endmodule

// [rtl/ocp_irq.sv]
// Purpose: Sticky event status with mask and one level interrupt.
// Assumes: Write-one-to-clear; a set in the same cycle wins.
// Notes:   Width is a parameter.
`timescale 1ns/100ps
module ocp_irq #(
  parameter int unsigned N = 2
) (
  // Clock and control
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Events and software access
  input  wire logic [N-1:0] i_event,
  input  wire logic [N-1:0] i_clr,
  input  wire logic [N-1:0] i_mask,
  // Outputs
  output logic [N-1:0]      o_status,
  output logic              o_irq
);
  logic [N-1:0] stat_reg;
  logic [N-1:0] stat_next;

  // Set wins over clear so no event is lost
  assign stat_next = (stat_reg & ~i_clr) | i_event;
  assign o_status  = stat_reg;
  assign o_irq     = |(stat_reg & i_mask);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_reg <= '0;
    end else if (i_ce) begin
      stat_reg <= stat_next;
    end
  end
endmodule

// [rtl/ocp_pkg.sv]
// Purpose: Shared constants and types for the over-charge protection state machine.
// Assumes: Internal oscillator clock of 100 MHz.
// Notes:   Delay times are kept in their printed units; cycle counts derive from them.
package ocp_pkg;
  // ==========================================================================
  // Clock and delay timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DET_DELAY_MS    = 1000;  // 1.00 s detect delay
  localparam int unsigned REL_DELAY_US    = 16000; // 16.0 ms release delay
  localparam int unsigned DET_CYCLES      = DET_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned REL_CYCLES      = REL_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHORTEN_DIV     = 60;    // Shortened delay is about 1/60
  localparam int unsigned CNT_W           = 28;

  // ==========================================================================
  // Register map (Avalon-MM word addresses)
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h3;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] MASK_RST        = 32'h0000_0000;

  // ==========================================================================
  // Event bits in the interrupt status
  localparam int unsigned EV_DETECT       = 0;
  localparam int unsigned EV_RELEASE      = 1;
  localparam int unsigned EV_W            = 2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    OCP_NORMAL   = 2'b00,
    OCP_DET_WAIT = 2'b01,
    OCP_OVER     = 2'b10,
    OCP_REL_WAIT = 2'b11
  } ocp_state_t;

  typedef struct packed {
    logic above_thr;     // Supply above overcharge_threshold
    logic at_release;    // Supply at or below overcharge_release_level
    logic charger;       // Charger attached
    logic load;          // discharge_overcurrent_threshold reached
    logic shorten;       // delay_shorten_mode active
    logic below_inhibit; // Supply below charge inhibit level
  } ocp_cmp_t;

  typedef struct packed {
    logic auto_release;  // 1: auto-release variant, 0: latch
    logic zero_v_ok;     // 1: zero-volt charge accepted
  } ocp_cfg_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ocp_av_req_t;
endpackage

// [verification/ocp_analog_model.sv]
// Purpose: Comparator front end facing the over-charge state machine.
// Assumes: Supply given in millivolts; trip levels are plain defaults.
// Notes:   A load lifts the sense node past the discharge over-current trip.
`timescale 1ns/100ps
module ocp_analog_model
  import ocp_pkg::*;
#(
  parameter int THR_MV = 4250,
  parameter int REL_MV = 4050,
  parameter int INH_MV = 1100
) (
  // Pack conditions
  input  wire logic [12:0]  i_supply_mv,
  input  wire logic         i_charger,
  input  wire logic         i_load,
  input  wire logic         i_shorten,
  // Comparator results
  output wire ocp_pkg::ocp_cmp_t o_cmp
);
  // ==========================================================================
  // Comparators, ideal and without hysteresis
  assign o_cmp.above_thr     = (i_supply_mv > THR_MV);
  assign o_cmp.at_release    = (i_supply_mv <= REL_MV);
  assign o_cmp.charger       = i_charger;
  assign o_cmp.load          = i_load;
  assign o_cmp.shorten       = i_shorten;
  assign o_cmp.below_inhibit = (i_supply_mv < INH_MV);
endmodule

// [verification/ocp_fsm_bench.sv]
// Purpose: Self-checking bench for the over-charge state machine.
// Assumes: Shortened delay parameters; comparators come from the model.
// Notes:   Outputs are read at rising edges, before that edge's updates.
`timescale 1ns/100ps
module ocp_fsm_bench;
  import ocp_pkg::*;
  localparam int DET = 60;
  localparam int REL = 12;
  localparam int SHR = 6;
  typedef struct {
    logic        auto_rel;
    logic        chg;
    logic        ld;
    logic [12:0] mv;
    logic        en;
  } ocp_row_t;
  // ==========================================================================
  // Stimulus and observed signals
  logic        i_clk     = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_ce      = 1'b1;
  ocp_cfg_t    cfg       = '0;
  ocp_av_req_t av        = '0;
  logic [12:0] supply_mv = 13'h0E74;
  logic        charger   = 1'b0;
  logic        load      = 1'b0;
  logic        shorten   = 1'b0;
  ocp_cmp_t    cmp;
  logic [31:0] rdata;
  logic        waitreq;
  logic        charge_en;
  logic        irq;
  int          failures  = 0;
  int          checks    = 0;
  // Release cases after an over-charge with charger attached
  ocp_row_t rows [7] = '{
    '{1'b0, 1'b1, 1'b0, 13'h0FA0, 1'b0}, // Latch, charger kept, low supply
    '{1'b0, 1'b0, 1'b0, 13'h1068, 1'b1}, // Latch, charger removed
    '{1'b0, 1'b1, 1'b1, 13'h1068, 1'b1}, // Latch, load drains supply
    '{1'b1, 1'b1, 1'b0, 13'h0FA0, 1'b1}, // Auto, at release level
    '{1'b1, 1'b0, 1'b0, 13'h1068, 1'b1}, // Auto, charger removed
    '{1'b1, 1'b1, 1'b1, 13'h1068, 1'b1}, // Auto, load seen
    '{1'b1, 1'b1, 1'b0, 13'h1068, 1'b0}  // Auto, between levels, charger kept
  };
  always #5 i_clk = ~i_clk;
  ocp_fsm #(.DET_CNT(DET), .REL_CNT(REL), .SHR_DIV(SHR)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmp(cmp), .i_cfg(cfg), .i_av(av),
    .o_av_readdata(rdata), .o_av_waitrequest(waitreq), .o_charge_en(charge_en),
    .o_irq(irq));
  ocp_analog_model analog (
    .i_supply_mv(supply_mv), .i_charger(charger), .i_load(load), .i_shorten(shorten),
    .o_cmp(cmp));
  // ==========================================================================
  // Tasks
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge i_clk);
    av <= '{address: addr, read: !wr, write: wr, writedata: wd};
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (waitreq === 1'b0) break;
    end
    rd = rdata;
    av <= '0;
    if (k == 20) begin
      failures++;
      finish_test();
    end
  endtask
  // Edges until the enable shows lvl; cnt equals max when it never does
  task automatic wait_en(input logic lvl, input int max, output int cnt);
    for (cnt = 0; cnt < max; cnt++) begin
      @(posedge i_clk);
      if (charge_en === lvl) break;
    end
  endtask
  task automatic restart(input logic auto_rel, input logic zv);
    @(posedge i_clk);
    i_rst <= 1'b1;
    cfg <= '{auto_release: auto_rel, zero_v_ok: zv};
    supply_mv <= 13'h0E74;
    charger <= 1'b0;
    load <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  // Charger pushes the supply over the trip level
  task automatic detect(output int cnt);
    @(posedge i_clk);
    supply_mv <= 13'h10CC;
    charger <= 1'b1;
    wait_en(1'b0, DET + 20, cnt);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    int          n;
    shorten <= 1'b0;
    foreach (rows[i]) begin
      restart(rows[i].auto_rel, 1'b1);
      detect(n);
      chk("detect delay", 1, n >= DET - 1 && n < DET + 20);
      supply_mv <= rows[i].mv;
      charger <= rows[i].chg;
      load <= rows[i].ld;
      wait_en(1'b1, REL + 20, n);
      chk("release", rows[i].en, n >= REL - 1 && n < REL + 20);
      $display("test row %0d done", i);
    end
    // Reset in mid-run, from over-charge, back to normal
    restart(1'b0, 1'b1);
    @(posedge i_clk);
    chk("enable after reset", 1, charge_en);
    bus(1'b0, ADDR_STATUS, 0, r);
    chk("status after reset", 32'h8, r);
    bus(1'b0, ADDR_CTRL, 0, r);
    chk("ctrl after reset", CTRL_RST, r);
    bus(1'b0, ADDR_IRQ_MASK, 0, r);
    chk("mask after reset", MASK_RST, r);
    bus(1'b0, 4'hF, 0, r);
    chk("unmapped read", 0, r);
    $display("test reset done");
    // Short dip below the trip level restarts the detect delay
    restart(1'b0, 1'b1);
    supply_mv <= 13'h10CC;
    charger <= 1'b1;
    repeat (30) @(posedge i_clk);
    supply_mv <= 13'h0E74;
    repeat (2) @(posedge i_clk);
    supply_mv <= 13'h10CC;
    wait_en(1'b0, 45, n);
    chk("detect after dip", 45, n);
    wait_en(1'b0, 40, n);
    chk("detect after dip late", 1, n < 40);
    bus(1'b0, ADDR_STATUS, 0, r);
    chk("status in over-charge", 32'h2, r);
    // Release condition shorter than the release delay
    supply_mv <= 13'h1068;
    charger <= 1'b0;
    repeat (5) @(posedge i_clk);
    supply_mv <= 13'h10CC;
    wait_en(1'b1, 30, n);
    chk("release after short recovery", 30, n);
    $display("test persistence done");
    // Interrupt raised, cleared, and masked; override picks auto release
    restart(1'b0, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h3, r);
    bus(1'b0, ADDR_CTRL, 0, r);
    chk("ctrl written", 32'h3, r);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1, r);
    detect(n);
    bus(1'b0, ADDR_IRQ_STAT, 0, r);
    chk("detect event", 32'h1, r);
    chk("irq raised", 1, irq);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1, r);
    @(posedge i_clk);
    chk("irq cleared", 0, irq);
    supply_mv <= 13'h0FA0;
    wait_en(1'b1, REL + 20, n);
    chk("release with override", 1, n < REL + 20);
    bus(1'b0, ADDR_IRQ_STAT, 0, r);
    chk("release event", 32'h2, r);
    chk("masked irq", 0, irq);
    $display("test interrupt done");
    // Shorten mode cuts both delays
    restart(1'b0, 1'b1);
    shorten <= 1'b1;
    detect(n);
    chk("short detect", 1, n >= DET / SHR - 1 && n < DET / SHR + 8);
    supply_mv <= 13'h1068;
    charger <= 1'b0;
    wait_en(1'b1, 20, n);
    chk("short release", 1, n < REL / SHR + 8);
    shorten <= 1'b0;
    $display("test shorten done");
    // Clock enable low freezes the detect delay
    restart(1'b0, 1'b1);
    supply_mv <= 13'h10CC;
    charger <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (30) @(posedge i_clk);
    i_ce <= 1'b1;
    wait_en(1'b0, 60, n);
    chk("detect after enable pause", 1, n >= 30 && n < 60);
    $display("test clock enable done");
    // Zero-volt inhibit only in the variant that refuses it
    restart(1'b0, 1'b0);
    supply_mv <= 13'h01F4;
    charger <= 1'b1;
    wait_en(1'b0, 10, n);
    chk("inhibit drop", 1, n < 10);
    bus(1'b0, ADDR_STATUS, 0, r);
    chk("inhibit status", 32'h4, r);
    restart(1'b0, 1'b1);
    supply_mv <= 13'h01F4;
    charger <= 1'b1;
    wait_en(1'b0, 10, n);
    chk("zero volt accepted", 10, n);
    $display("test inhibit done");
    finish_test();
  end
endmodule
